// ==== src/ebwt_sequencer.sv ====
// External bus sequencer: timing registers, write cycle phases, fetch bursts and reads.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module ebwt_sequencer
  import ebwt_pkg::*;
#(
  parameter int HALF_DIV    = HALF_DIV_DEFAULT,
  parameter int READ_HALVES = READ_BEAT_HALVES
)
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic [7:0]       reg_rdata,
  input  ebwt_req_t        req,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [15:0] bus_rdata,
  output logic [15:0]      rsp_data,
  output logic             rsp_valid,
  output ebwt_pins_t       pins
);

  typedef enum logic [2:0] {ST_IDLE, ST_ALE, ST_GAP, ST_SETUP, ST_STROBE, ST_HOLD, ST_BEAT}
    ebwt_state_t;
  ebwt_state_t st_q;
  ebwt_state_t st_d;
  logic [7:0]  upper_q;
  logic [7:0]  lower_q;
  logic        cfg_err_q;
  logic [7:0]  reg_rdata_q;
  ebwt_cfg_t   snap_q;
  ebwt_cfg_t   cfg_live;
  ebwt_cfg_t   cfg_use;
  ebwt_req_t   cur_q;
  ebwt_req_t   sel;
  ebwt_phase_t phase;
  ebwt_pins_t  pins_q;
  logic [3:0]  cnt_q;
  logic [3:0]  len_d;
  logic [3:0]  beats_q;
  logic [7:0]  div_q;
  logic        half_tick;
  logic        ready_q;
  logic        take;
  logic        refuse;
  logic        beat_end;
  logic [15:0] rsp_data_q;
  logic        rsp_valid_q;
  assign cfg_live = '{latched_write_len: upper_q[UP_LATCHED_LSB +: 2],
                      unlatched_write_len: upper_q[UP_UNLATCHED_LSB +: 2],
                      write_hold_extend: lower_q[LO_HOLD_BIT],
                      write_strobe_width_sel: lower_q[LO_STROBE_BIT],
                      latch_pulse_width_sel: lower_q[LO_LATCH_BIT],
                      bus8: lower_q[LO_BUS8_BIT]};
  // A cycle in flight keeps the timing it started with, whatever software writes meanwhile.
  assign cfg_use   = (st_q == ST_IDLE) ? cfg_live : snap_q;
  assign sel       = (st_q == ST_IDLE) ? req : cur_q;
  assign half_tick = (div_q == 8'h00);
  assign reg_rdata = reg_rdata_q;
  assign req_ready = ready_q;
  assign rsp_data  = rsp_data_q;
  assign rsp_valid = rsp_valid_q;
  assign pins      = pins_q;
  ebwt_phase_calc u_calc (
    .cfg     (cfg_use),
    .latched (sel.latched),
    .phase   (phase)
  );
  // Half clock enable; every phase counter step is one half clock.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      div_q <= 8'h00;
    else
      div_q <= (div_q >= 8'(HALF_DIV - 1)) ? 8'h00 : div_q + 8'h01;
  end
  always_comb
  begin
    st_d     = st_q;
    len_d    = cnt_q;
    take     = 1'b0;
    refuse   = 1'b0;
    beat_end = 1'b0;
    case (st_q)
      ST_IDLE:
      begin
        if (req_valid && ready_q)
        begin
          if (req.op == EBWT_OP_WRITE && !phase.valid)
            refuse = 1'b1;
          else if (req.op == EBWT_OP_WRITE)
          begin
            take = 1'b1;
            if (phase.ale != 4'h0)
            begin
              st_d  = ST_ALE;
              len_d = phase.ale;
            end
            else if (phase.setup != 4'h0)
            begin
              st_d  = ST_SETUP;
              len_d = phase.setup;
            end
            else
            begin
              st_d  = ST_STROBE;
              len_d = phase.strobe;
            end
          end
          else
          begin
            take  = 1'b1;
            st_d  = ST_BEAT;
            len_d = 4'(READ_HALVES);
          end
        end
      end
      default:
      begin
        if (half_tick && cnt_q <= 4'h1)
        begin
          case (st_q)
            ST_ALE:
            begin
              st_d  = ST_GAP;
              len_d = phase.gap;
            end
            ST_GAP:
            begin
              st_d  = (phase.setup != 4'h0) ? ST_SETUP : ST_STROBE;
              len_d = (phase.setup != 4'h0) ? phase.setup : phase.strobe;
            end
            ST_SETUP:
            begin
              st_d  = ST_STROBE;
              len_d = phase.strobe;
            end
            ST_STROBE:
            begin
              st_d  = (phase.hold != 4'h0) ? ST_HOLD : ST_IDLE;
              len_d = phase.hold;
            end
            ST_BEAT:
            begin
              beat_end = 1'b1;
              st_d     = (beats_q > 4'h1) ? ST_BEAT : ST_IDLE;
              len_d    = 4'(READ_HALVES);
            end
            default:
            begin
              st_d  = ST_IDLE;
              len_d = 4'h0;
            end
          endcase
        end
      end
    endcase
  end
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q    <= ST_IDLE;
      cnt_q   <= 4'h0;
      ready_q <= 1'b1;
    end
    else
    begin
      st_q    <= st_d;
      ready_q <= (st_d == ST_IDLE);
      if (take || beat_end || st_d != st_q)
        cnt_q <= len_d;
      else if (half_tick && cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur_q   <= '0;
      snap_q  <= '0;
      beats_q <= 4'h0;
    end
    else if (take)
    begin
      cur_q   <= req;
      snap_q  <= cfg_live;
      if (req.op == EBWT_OP_FETCH)
        beats_q <= (req.beats == 4'h0) ? 4'h1 : req.beats;
      else
        beats_q <= (req.op == EBWT_OP_READ && req.wide && cfg_live.bus8) ? 4'h2 : 4'h1;
    end
    else if (beat_end)
      beats_q <= beats_q - 4'h1;
  end
  // Pins follow the state being entered, so each strobe edge lands on its phase boundary.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      pins_q <= PINS_IDLE;
    else
    begin
      pins_q.addr_latch <= (st_d == ST_ALE);
      pins_q.data_oe    <= (sel.op == EBWT_OP_WRITE) &&
                           (st_d == ST_SETUP || st_d == ST_STROBE || st_d == ST_HOLD);
      pins_q.write_strobe_low_byte_n  <= !(st_d == ST_STROBE && sel.byte_en[0]);
      pins_q.write_strobe_high_byte_n <= !(st_d == ST_STROBE && sel.byte_en[1]);
      // One strobe spans every beat of a burst or a split word read.
      pins_q.program_store_strobe_n <= !(st_d == ST_BEAT && sel.op == EBWT_OP_FETCH);
      pins_q.read_strobe_n          <= !(st_d == ST_BEAT && sel.op == EBWT_OP_READ);
      if (take)
      begin
        pins_q.addr  <= (req.op == EBWT_OP_READ && req.wide && cfg_live.bus8) ?
                        {req.addr[19:1], 1'b0} : req.addr;
        pins_q.wdata <= req.data;
      end
      else if (beat_end && st_d == ST_BEAT)
      begin
        if (cur_q.op == EBWT_OP_FETCH)
          pins_q.addr <= pins_q.addr + (snap_q.bus8 ? 20'h00001 : 20'h00002);
        else
          pins_q.addr <= {pins_q.addr[19:1], 1'b1};
      end
    end
  end
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rsp_data_q  <= 16'h0000;
      rsp_valid_q <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= beat_end && (cur_q.op == EBWT_OP_FETCH || beats_q == 4'h1);
      if (beat_end)
      begin
        if (cur_q.op == EBWT_OP_READ && cur_q.wide && snap_q.bus8)
        begin
          if (beats_q == 4'h2)
            rsp_data_q[7:0] <= bus_rdata[7:0];
          else
            rsp_data_q[15:8] <= bus_rdata[7:0];
        end
        else
          rsp_data_q <= snap_q.bus8 ? {8'h00, bus_rdata[7:0]} : bus_rdata;
      end
    end
  end

  // Timing registers; a refused write wins over a clear of the error flag in the same cycle.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      upper_q   <= UPPER_RST;
      lower_q   <= LOWER_RST;
      cfg_err_q <= 1'b0;
    end
    else
    begin
      if (reg_we && reg_addr == OFF_TIMING_UPPER)
        upper_q <= {4'h0, reg_wdata[3:0]};
      if (reg_we && reg_addr == OFF_TIMING_LOWER)
        lower_q <= {4'h0, reg_wdata[3:0]};
      if (refuse)
        cfg_err_q <= 1'b1;
      else if (reg_we && reg_addr == OFF_STATUS && reg_wdata[ST_CFG_ERR_BIT])
        cfg_err_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata_q <= 8'h00;
    else if (!reg_re)
      reg_rdata_q <= 8'h00;
    else
      case (reg_addr)
        OFF_TIMING_UPPER: reg_rdata_q <= upper_q;
        OFF_TIMING_LOWER: reg_rdata_q <= lower_q;
        OFF_STATUS:
        begin
          reg_rdata_q                 <= 8'h00;
          reg_rdata_q[ST_BUSY_BIT]    <= (st_q != ST_IDLE);
          reg_rdata_q[ST_CFG_ERR_BIT] <= cfg_err_q;
          reg_rdata_q[ST_CFG_OK_BIT]  <= phase.valid;
        end
        default: reg_rdata_q <= 8'h00;
      endcase
  end

endmodule

// ==== src/ebwt_pkg.sv ====
// Shared constants, field layouts and carrier types of the external bus write timing block.
package ebwt_pkg;

  localparam logic [3:0] OFF_TIMING_UPPER = 4'h0;
  localparam logic [3:0] OFF_TIMING_LOWER = 4'h1;
  localparam logic [3:0] OFF_STATUS       = 4'h2;

  localparam int UP_UNLATCHED_LSB = 0;
  localparam int UP_LATCHED_LSB   = 2;
  localparam int LO_HOLD_BIT      = 0;
  localparam int LO_STROBE_BIT    = 1;
  localparam int LO_LATCH_BIT     = 2;
  localparam int LO_BUS8_BIT      = 3;
  localparam int ST_BUSY_BIT      = 0;
  localparam int ST_CFG_ERR_BIT   = 1;
  localparam int ST_CFG_OK_BIT    = 2;

  localparam logic [7:0] UPPER_RST = 8'h0F;
  localparam logic [7:0] LOWER_RST = 8'h01;

  localparam int LEN_BASE_CLKS      = 2;
  localparam int HALVES_PER_CLK     = 2;
  localparam int STROBE_NARROW_CLKS = 1;
  localparam int STROBE_WIDE_CLKS   = 2;
  localparam int HOLD_EXT_CLKS      = 1;
  localparam int ALE_NARROW_HALVES  = 1;
  localparam int ALE_WIDE_HALVES    = 3;
  localparam int LATCH_GAP_HALVES   = 1;
  localparam int READ_BEAT_HALVES   = 4;
  localparam int HALF_DIV_DEFAULT   = 1;

  typedef enum logic [1:0] {EBWT_OP_WRITE, EBWT_OP_READ, EBWT_OP_FETCH} ebwt_op_t;

  typedef struct packed {
    logic [1:0] latched_write_len;
    logic [1:0] unlatched_write_len;
    logic       write_hold_extend;
    logic       write_strobe_width_sel;
    logic       latch_pulse_width_sel;
    logic       bus8;
  } ebwt_cfg_t;

  typedef struct packed {
    logic [3:0] ale;
    logic [3:0] gap;
    logic [3:0] setup;
    logic [3:0] strobe;
    logic [3:0] hold;
    logic       valid;
  } ebwt_phase_t;

  typedef struct packed {
    ebwt_op_t    op;
    logic        latched;
    logic        wide;
    logic [1:0]  byte_en;
    logic [3:0]  beats;
    logic [19:0] addr;
    logic [15:0] data;
  } ebwt_req_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] wdata;
    logic        data_oe;
    logic        addr_latch;
    logic        write_strobe_low_byte_n;
    logic        write_strobe_high_byte_n;
    logic        program_store_strobe_n;
    logic        read_strobe_n;
  } ebwt_pins_t;

  localparam ebwt_pins_t PINS_IDLE = '{addr: 20'h00000, wdata: 16'h0000, data_oe: 1'b0,
    addr_latch: 1'b0, write_strobe_low_byte_n: 1'b1, write_strobe_high_byte_n: 1'b1,
    program_store_strobe_n: 1'b1, read_strobe_n: 1'b1};

endpackage

// ==== src/ebwt_phase_calc.sv ====
// Write cycle phase lengths in half clocks from the timing configuration.
`timescale 1ns/1ps
module ebwt_phase_calc
  import ebwt_pkg::*;
(
  input  ebwt_cfg_t   cfg,
  input  wire logic   latched,
  output ebwt_phase_t phase
);

  int total;
  int strobe;
  int hold;
  int ale;
  int gap;
  int setup;

  always_comb
  begin
    total  = HALVES_PER_CLK * (LEN_BASE_CLKS + int'(latched ? cfg.latched_write_len
                                                             : cfg.unlatched_write_len));
    strobe = HALVES_PER_CLK * (cfg.write_strobe_width_sel ? STROBE_WIDE_CLKS
                                                          : STROBE_NARROW_CLKS);
    hold   = cfg.write_hold_extend ? HALVES_PER_CLK * HOLD_EXT_CLKS : 0;
    ale    = latched ? (cfg.latch_pulse_width_sel ? ALE_WIDE_HALVES : ALE_NARROW_HALVES) : 0;
    gap    = latched ? LATCH_GAP_HALVES : 0;
    // Latched setup loses the latch width plus the half clock of address hold.
    setup  = total - strobe - hold - ale - gap;
    phase.ale    = 4'(ale);
    phase.gap    = 4'(gap);
    phase.setup  = (setup < 0) ? 4'h0 : 4'(setup);
    phase.strobe = 4'(strobe);
    phase.hold   = 4'(hold);
    phase.valid  = (setup >= 0) && cfg.write_hold_extend;
  end

endmodule

// ==== verification/ebwt_seq_monitor.sv ====
// Port assertions for the external bus write timing sequencer.
`timescale 1ns/1ps
module ebwt_seq_monitor
  import ebwt_pkg::*;
#(
  parameter int HALF_DIV    = HALF_DIV_DEFAULT,
  parameter int READ_HALVES = READ_BEAT_HALVES
)
(
  input wire logic  ref_clk,
  input wire logic  nrst,
  input logic       req_ready,
  input ebwt_pins_t pins
);
  // The figures below assume one clock cycle for each half bus clock.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  AST_OE_UNDER_STROBE: assert property (!pins.write_strobe_low_byte_n |-> pins.data_oe)
    else $error("Write strobe low without driven data.");
  AST_HOLD_ONE_CLOCK: assert property ($rose(pins.write_strobe_low_byte_n) |->
    pins.data_oe [*2] ##1 !pins.data_oe)
    else $error("Write data hold is not one clock.");
  AST_STROBE_WIDTH: assert property ($fell(pins.write_strobe_low_byte_n) |->
    (!pins.write_strobe_low_byte_n [*2] ##1 pins.write_strobe_low_byte_n) or
    (!pins.write_strobe_low_byte_n [*4] ##1 pins.write_strobe_low_byte_n))
    else $error("Write strobe is neither one nor two clocks.");
  AST_BUSY_IN_STROBE: assert property (!pins.write_strobe_low_byte_n |-> !req_ready)
    else $error("Ready while the write strobe is low.");
  AST_LATCH_GAP: assert property ($fell(pins.addr_latch) |->
    pins.write_strobe_low_byte_n && pins.read_strobe_n)
    else $error("Strobe follows the latch pulse without a gap.");
  AST_SINGLE_READ_STROBE: assert property (!pins.read_strobe_n && !$past(pins.read_strobe_n) |->
    !$fell(pins.addr[0]))
    else $error("Address bit 0 fell inside one read strobe.");
  AST_FETCH_BEAT: assert property ($fell(pins.program_store_strobe_n) |->
    !pins.program_store_strobe_n [*4])
    else $error("Program store strobe shorter than one beat.");
  AST_MIN_CYCLE: assert property ($fell(req_ready) |-> !req_ready [*4])
    else $error("Bus cycle shorter than two clocks.");
endmodule

// ==== verification/ebwt_mem_model.sv ====
// Behavioural external memory that answers the sequencer's bus pins.
`timescale 1ns/1ps
module ebwt_mem_model
  import ebwt_pkg::*;
(
  input wire logic    ref_clk,
  input wire logic    nrst,
  input ebwt_pins_t   pins,
  output logic [15:0] bus_rdata,
  output logic [15:0] last_wr,
  output logic [3:0]  fetch_starts,
  output logic [3:0]  a0_rises
);
  logic        idle_q;
  logic        pss_q;
  logic [19:0] addr_q;

  function automatic logic [7:0] mbyte(input logic [19:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction

  // A released bus toggles every cycle, so stale data can never match by luck.
  assign bus_rdata = (!pins.read_strobe_n || !pins.program_store_strobe_n) ?
    {mbyte(pins.addr | 20'h00001), mbyte(pins.addr)} : {16{idle_q}};

  // No wait logic is modelled, so no read is ever stretched.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      idle_q <= 1'h0;
      pss_q <= 1'h1;
      addr_q <= 20'h00000;
      last_wr <= 16'h0000;
      fetch_starts <= 4'h0;
      a0_rises <= 4'h0;
    end
    else
    begin
      idle_q <= ~idle_q;
      pss_q <= pins.program_store_strobe_n;
      addr_q <= pins.addr;
      if (!pins.write_strobe_low_byte_n)
        last_wr <= pins.wdata;
      // Only a 16-bit bus fetches here, so lines 3 to 1 mark a new cycle.
      if (!pins.program_store_strobe_n && (pss_q || pins.addr[3:1] != addr_q[3:1]))
        fetch_starts <= fetch_starts + 4'h1;
      if (!pins.read_strobe_n && pins.addr[0] && !addr_q[0])
        a0_rises <= a0_rises + 4'h1;
    end
  end
endmodule

// ==== verification/ebwt_sequencer_tb.sv ====
// Self-checking bench for the external bus write timing sequencer.
`timescale 1ns/1ps
module ebwt_sequencer_tb;
  import ebwt_pkg::*;
  typedef struct packed {
    logic [7:0] up;
    logic [7:0] lo;
    logic       lat;
    logic [3:0] su;
    logic [3:0] st;
    logic [3:0] al;
    logic [3:0] bz;
  } ebwt_row_t;
  // Upper, lower, latched, then setup, strobe, latch and busy in half clocks.
  localparam ebwt_row_t ROWS [9] = '{
    '{8'h0F, 8'h01, 1'h1, 4'h4, 4'h2, 4'h1, 4'hA}, '{8'h0F, 8'h05, 1'h1, 4'h2, 4'h2, 4'h3, 4'hA},
    '{8'h0F, 8'h03, 1'h1, 4'h2, 4'h4, 4'h1, 4'hA}, '{8'h00, 8'h01, 1'h0, 4'h0, 4'h2, 4'h0, 4'h4},
    '{8'h01, 8'h03, 1'h0, 4'h0, 4'h4, 4'h0, 4'h6}, '{8'h02, 8'h01, 1'h0, 4'h4, 4'h2, 4'h0, 4'h8},
    '{8'h03, 8'h03, 1'h0, 4'h4, 4'h4, 4'h0, 4'hA}, '{8'h04, 8'h01, 1'h1, 4'h0, 4'h2, 4'h1, 4'h6},
    '{8'h08, 8'h01, 1'h1, 4'h2, 4'h2, 4'h1, 4'h8}};
  logic        ref_clk;
  logic        nrst;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_we;
  logic        reg_re;
  logic [7:0]  reg_rdata;
  ebwt_req_t   req;
  logic        req_valid;
  logic        req_ready;
  logic [15:0] bus_rdata;
  logic [15:0] rsp_data;
  logic        rsp_valid;
  ebwt_pins_t  pins;
  logic [15:0] last_wr;
  logic [3:0]  fetch_starts;
  logic [3:0]  a0_rises;
  logic [7:0]  rv;
  logic [15:0] rs;
  int          miscompares;
  int          checks_done;
  logic [15:0] wd;
  int          su, st, sh, al, bz, ps, rr, nrsp;

  initial ref_clk = 1'h0;
  always #10 ref_clk = ~ref_clk;

  ebwt_sequencer #(.HALF_DIV(1), .READ_HALVES(4)) dut (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .bus_rdata(bus_rdata), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .pins(pins));
  ebwt_mem_model model (.ref_clk(ref_clk), .nrst(nrst), .pins(pins), .bus_rdata(bus_rdata),
    .last_wr(last_wr), .fetch_starts(fetch_starts), .a0_rises(a0_rises));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'h1;
    @(posedge ref_clk);
    reg_we <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_re <= 1'h1;
    @(posedge ref_clk);
    reg_re <= 1'h0;
    #1;
    rv = reg_rdata;
  endtask

  // Issues one request and counts pin phases over a window longer than any cycle.
  task automatic run(input ebwt_op_t op, input logic lat, input logic [19:0] a);
    logic prv;
    @(posedge ref_clk);
    req <= '{op: op, latched: lat, wide: 1'h1, byte_en: 2'h3, beats: 4'h2, addr: a,
      data: wd};
    req_valid <= 1'h1;
    @(posedge ref_clk);
    chk(16'(req_ready), 16'h0001);
    req_valid <= 1'h0;
    {su, st, sh, al, bz, ps, rr, nrsp} = '0;
    prv = 1'h1;
    // The first look falls right after the taking edge, where the first phase already shows.
    for (int i = 0; i < 30; i++)
    begin
      #1;
      if (!pins.write_strobe_low_byte_n)
        st++;
      else if (pins.data_oe && st == 0)
        su++;
      sh += int'(!pins.write_strobe_high_byte_n);
      al += int'(pins.addr_latch);
      bz += int'(!req_ready);
      ps += int'(!pins.program_store_strobe_n);
      rr += int'(pins.read_strobe_n && !prv);
      prv = pins.read_strobe_n;
      if (rsp_valid)
      begin
        nrsp++;
        rs = rsp_data;
      end
      @(posedge ref_clk);
    end
  endtask

  initial
  begin
    {nrst, reg_addr, reg_wdata, reg_we, reg_re, req_valid} = '0;
    req = '0;
    wd = 16'hC3A5;
    miscompares = 0;
    checks_done = 0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'h1;
    rd(OFF_TIMING_UPPER);
    chk(16'(rv), 16'(UPPER_RST));
    rd(OFF_TIMING_LOWER);
    chk(16'(rv), 16'(LOWER_RST));
    rd(4'hF);
    chk(16'(rv), 16'h0000);
    $display("Reset values test done.");
    foreach (ROWS[k])
    begin
      wd = 16'hC3A5 ^ 16'(k);
      wr(OFF_TIMING_UPPER, ROWS[k].up);
      wr(OFF_TIMING_LOWER, ROWS[k].lo);
      run(EBWT_OP_WRITE, ROWS[k].lat, 20'h0000A);
      chk(16'(su), 16'(ROWS[k].su));
      chk(16'(st), 16'(ROWS[k].st));
      chk(16'(sh), 16'(ROWS[k].st));
      chk(16'(al), 16'(ROWS[k].al));
      chk(16'(bz), 16'(ROWS[k].bz));
      chk(last_wr, wd);
    end
    $display("Write timing table test done.");
    // Without the hold extension a write must leave the bus untouched.
    wr(OFF_TIMING_LOWER, 8'h00);
    run(EBWT_OP_WRITE, 1'h0, 20'h0000A);
    chk(16'(bz + st), 16'h0000);
    rd(OFF_STATUS);
    chk(16'(rv & 8'h03), 16'h0002);
    wr(OFF_STATUS, 8'h02);
    rd(OFF_STATUS);
    chk(16'(rv & 8'h03), 16'h0000);
    wr(OFF_TIMING_UPPER, 8'h00);
    wr(OFF_TIMING_LOWER, 8'h01);
    run(EBWT_OP_WRITE, 1'h1, 20'h0000A);
    chk(16'(bz + st), 16'h0000);
    rd(OFF_STATUS);
    chk(16'(rv & 8'h06), 16'h0002);
    $display("Refused write test done.");
    wr(OFF_STATUS, 8'h02);
    run(EBWT_OP_FETCH, 1'h0, 20'h00100);
    chk(16'(ps), 16'h0008);
    chk(16'(nrsp), 16'h0002);
    chk(rs, 16'h5958);
    chk(16'(fetch_starts), 16'h0002);
    $display("Burst fetch test done.");
    wr(OFF_TIMING_LOWER, 8'h09);
    run(EBWT_OP_READ, 1'h0, 20'h00200);
    chk(16'(rr), 16'h0001);
    chk(16'(nrsp), 16'h0001);
    chk(rs, 16'h5B5A);
    chk(16'(a0_rises), 16'h0001);
    $display("Split read test done.");
    // A reset in the middle of a write drops the bus at once and restores the timing registers.
    wr(OFF_TIMING_UPPER, 8'h03);
    @(posedge ref_clk);
    req <= '{op: EBWT_OP_WRITE, latched: 1'h0, wide: 1'h0, byte_en: 2'h3, beats: 4'h1,
      addr: 20'h00030, data: 16'h1234};
    req_valid <= 1'h1;
    @(posedge ref_clk);
    req_valid <= 1'h0;
    repeat (5) @(posedge ref_clk);
    #1;
    chk(16'({req_ready, pins.data_oe}), 16'h0001);
    nrst <= 1'h0;
    #1;
    chk(16'({req_ready, pins.data_oe}), 16'h0002);
    chk(16'({pins.write_strobe_low_byte_n, pins.addr_latch}), 16'h0002);
    repeat (2) @(posedge ref_clk);
    nrst <= 1'h1;
    rd(OFF_TIMING_UPPER);
    chk(16'(rv), 16'(UPPER_RST));
    rd(OFF_TIMING_LOWER);
    chk(16'(rv), 16'(LOWER_RST));
    $display("Mid-run reset test done.");
    results();
  end
endmodule

bind ebwt_sequencer ebwt_seq_monitor #(.HALF_DIV(HALF_DIV), .READ_HALVES(READ_HALVES)) mon (
  .ref_clk(ref_clk), .nrst(nrst), .req_ready(req_ready), .pins(pins));
